// *** shared/sep_pkg.sv ***
// Shared constants and types for the serial EEPROM command port.
// Assumes a single 125 MHz ref_clk on both ends; all times but the typical program time are converted here.
package sep_pkg;

  // Array geometry (1024-word variant)
  localparam int SEP_ADDR_W = 10;
  localparam int SEP_DATA_W = 16;
  localparam int SEP_WORDS = 1024;
  localparam int SEP_FRAME_W = 1 + 2 + SEP_ADDR_W + SEP_DATA_W;
  localparam int SEP_SHORT_LEN = 1 + 2 + SEP_ADDR_W;
  localparam int SEP_FIFO_DEPTH = 8;

  // Opcodes and the two leading address bits of the special command
  localparam logic [1:0] SEP_OP_READ = 2'h2;
  localparam logic [1:0] SEP_OP_WRITE = 2'h1;
  localparam logic [1:0] SEP_OP_ERASE = 2'h3;
  localparam logic [1:0] SEP_OP_SPECIAL = 2'h0;
  localparam logic [1:0] SEP_LEAD_ENABLE = 2'h3;
  localparam logic [1:0] SEP_LEAD_DISABLE = 2'h0;

  // Values after reset
  localparam logic [15:0] SEP_ERASED_WORD = 16'hffff;
  localparam logic SEP_WEN_RESET = 1'b0;

  // Times in their own units and derived cycle counts
  localparam int SEP_CLK_NS = 8;
  localparam int SEP_PROG_MAX_MS = 10;
  localparam int SEP_PROG_TYP_MS = 4;
  localparam int SEP_PROG_CYC = SEP_PROG_MAX_MS * 1000000 / SEP_CLK_NS;
  localparam int SEP_DESEL_NS = 200;
  localparam int SEP_DESEL_CYC = (SEP_DESEL_NS + SEP_CLK_NS - 1) / SEP_CLK_NS;
  localparam int SEP_SK_PW_NS = 350;
  localparam int SEP_SK_HALF_CYC = (SEP_SK_PW_NS + SEP_CLK_NS - 1) / SEP_CLK_NS;
  localparam int SEP_SETTLE_CYC = 16;

  // Device command-port states
  typedef enum logic [2:0] {
    DS_IDLE, DS_OPC, DS_ADR, DS_WDATA, DS_READ, DS_HOLD
  } sep_dev_state_t;

  // Host sequencer states
  typedef enum logic [2:0] {
    HS_IDLE, HS_SEND, HS_RECV, HS_DESEL, HS_POLL
  } sep_host_state_t;

  // Host user commands
  typedef enum logic [2:0] {
    SC_READ, SC_WRITE, SC_ERASE, SC_ENABLE, SC_DISABLE
  } sep_cmd_t;

endpackage : sep_pkg

// *** shared/sep_link_if.sv ***
// Four-wire serial link between the EEPROM command port and its host.
// Assumes the bench instantiates it once and hands each modport to one end.
`timescale 1ns/1ns
interface sep_link_if;
  logic chipSelect;
  logic serialClock;
  logic serialIn;
  logic serialOut;
  logic serialOutOe;
  wire serialOutLine;

  // Board pull-up on the serial output: a released line reads high, so a
  // refused write or erase (no programming, output never enabled) polls ready
  assign serialOutLine = serialOutOe ? serialOut : 1'b1;

  modport dev (input chipSelect, input serialClock, input serialIn,
               output serialOut, output serialOutOe);
  modport host (output chipSelect, output serialClock, output serialIn,
                input serialOutLine);
endinterface : sep_link_if

// *** rtl/sep_device.sv ***
// Device end of the serial EEPROM: command decoder, array, programming timer.
// Assumes link pins are asynchronous to ref_clk and the host keeps its rules.
`timescale 1ns/1ns

// Three-stage pin sampler; a level moves only when stages two and three agree
module sep_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin side
  input wire logic [W-1:0] pinIn,
  // Filtered level
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  // Stage one feeds stage two only, to keep metastability out of the filter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign level = lvl_q;
endmodule : sep_sync

module sep_device
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = SEP_PROG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link
  sep_link_if.dev link,
  // Status
  output logic progBusy,
  output logic writeEnabled
);
  localparam logic [3:0] ADR_LAST = 4'(SEP_ADDR_W - 1);
  localparam logic [3:0] BIT_LAST = 4'(SEP_DATA_W - 1);
  localparam logic [4:0] DATA_FULL = 5'(SEP_DATA_W);
  localparam logic [20:0] PROG_LAST = 21'(PROG_CYCLES - 1);

  logic [2:0] pins;
  logic csOn;
  logic skLvl;
  logic diLvl;
  logic skPrev_q;
  logic csPrev_q;
  logic skRise;
  logic csFall;
  logic startSeen;
  logic progStart;
  logic progEnd;
  sep_dev_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [4:0] dataBits_q;
  logic [1:0] opc_q;
  logic [SEP_ADDR_W-1:0] addr_q;
  logic [SEP_DATA_W-1:0] data_q;
  logic wen_q;
  logic busy_q;
  logic verify_q;
  logic [20:0] progCnt_q;
  logic [SEP_ADDR_W-1:0] progAddr_q;
  logic [SEP_DATA_W-1:0] progWord_q;
  logic [SEP_DATA_W-1:0] mem_q [SEP_WORDS];
  logic doOut_q;
  logic doOe_q;

  sep_sync #(.W(3)) uPins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn({link.chipSelect, link.serialClock, link.serialIn}),
    .level(pins)
  );

  assign csOn = pins[2];
  assign skLvl = pins[1];
  assign diLvl = pins[0];

  // Edge detection on the filtered levels
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      skPrev_q <= 1'b0;
      csPrev_q <= 1'b0;
    end else begin
      skPrev_q <= skLvl;
      csPrev_q <= csOn;
    end
  end

  // Clock edges only count with chip select high
  assign skRise = csOn & skLvl & ~skPrev_q;
  assign csFall = csPrev_q & ~csOn;
  // Start bits are only looked for when not programming
  assign startSeen = (state_q == DS_IDLE) & skRise & diLvl & ~busy_q;
  // A short write (under 16 data bits) is not a full sequence and starts nothing
  assign progStart = csFall & wen_q & ~busy_q &
                     (((state_q == DS_WDATA) & (dataBits_q == DATA_FULL)) |
                      ((state_q == DS_HOLD) & (opc_q == SEP_OP_ERASE)));
  assign progEnd = busy_q & (progCnt_q == '0);

  // Instruction decoder
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= DS_IDLE;
      bitCnt_q <= '0;
      dataBits_q <= '0;
      opc_q <= '0;
      addr_q <= '0;
      data_q <= '0;
    end else if (!csOn) begin
      state_q <= DS_IDLE;
    end else if (skRise) begin
      case (state_q)
        DS_IDLE: begin
          if (startSeen) begin
            state_q <= DS_OPC;
            bitCnt_q <= '0;
          end
        end
        DS_OPC: begin
          opc_q <= {opc_q[0], diLvl};
          if (bitCnt_q == 4'h1) begin
            state_q <= DS_ADR;
            bitCnt_q <= '0;
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        DS_ADR: begin
          addr_q <= {addr_q[SEP_ADDR_W-2:0], diLvl};
          if (bitCnt_q == ADR_LAST) begin
            bitCnt_q <= '0;
            dataBits_q <= '0;
            if (opc_q == SEP_OP_READ) begin
              state_q <= DS_READ;
            end else if (opc_q == SEP_OP_WRITE) begin
              state_q <= DS_WDATA;
            end else begin
              state_q <= DS_HOLD;
            end
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        DS_WDATA: begin
          // Shift register keeps only the newest sixteen bits
          data_q <= {data_q[SEP_DATA_W-2:0], diLvl};
          if (dataBits_q != DATA_FULL) begin
            dataBits_q <= dataBits_q + 5'h1;
          end
        end
        DS_READ: begin
          if (bitCnt_q == BIT_LAST) begin
            bitCnt_q <= '0;
            addr_q <= addr_q + 1'b1;
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Write-enable latch, changed only by a complete special command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wen_q <= SEP_WEN_RESET;
    end else if (csFall && state_q == DS_HOLD && opc_q == SEP_OP_SPECIAL && !busy_q) begin
      if (addr_q[SEP_ADDR_W-1 -: 2] == SEP_LEAD_ENABLE) begin
        wen_q <= 1'b1;
      end else if (addr_q[SEP_ADDR_W-1 -: 2] == SEP_LEAD_DISABLE) begin
        wen_q <= 1'b0;
      end
    end
  end

  // Self-timed programming; the counter runs the full worst-case time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      progCnt_q <= '0;
      progAddr_q <= '0;
      progWord_q <= '0;
    end else if (progStart) begin
      busy_q <= 1'b1;
      progCnt_q <= PROG_LAST;
      progAddr_q <= addr_q;
      progWord_q <= (opc_q == SEP_OP_ERASE) ? SEP_ERASED_WORD : data_q;
    end else if (progEnd) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      progCnt_q <= progCnt_q - 21'h1;
    end
  end

  // Array; the word is replaced outright when programming ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SEP_WORDS; i++) begin
        mem_q[i] <= SEP_ERASED_WORD;
      end
    end else if (progEnd) begin
      mem_q[progAddr_q] <= progWord_q;
    end
  end

  // Ready/busy shown after every programming until the next start bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      verify_q <= 1'b0;
    end else if (progStart) begin
      verify_q <= 1'b1;
    end else if (startSeen) begin
      verify_q <= 1'b0;
    end
  end

  // Serial output driver
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      doOe_q <= 1'b0;
      doOut_q <= 1'b0;
    end else if (!csOn) begin
      doOe_q <= 1'b0;
    end else if (startSeen) begin
      doOe_q <= 1'b0;
    end else if (verify_q) begin
      doOe_q <= 1'b1;
      doOut_q <= ~busy_q;
    end else if (skRise && state_q == DS_ADR && bitCnt_q == ADR_LAST &&
                 opc_q == SEP_OP_READ) begin
      doOe_q <= 1'b1;
      doOut_q <= 1'b0;
    end else if (skRise && state_q == DS_READ) begin
      doOut_q <= mem_q[addr_q][BIT_LAST - bitCnt_q];
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      progBusy <= 1'b0;
      writeEnabled <= SEP_WEN_RESET;
    end else begin
      progBusy <= busy_q;
      writeEnabled <= wen_q;
    end
  end

  assign link.serialOut = doOut_q;
  assign link.serialOutOe = doOe_q;
endmodule : sep_device

// *** rtl/sep_host.sv ***
// Host end of the serial EEPROM link: frames commands, reads words, polls.
// Assumes sep_sync is compiled first; serial clock is divided from ref_clk.
`timescale 1ns/1ns

// Read-word buffer; depth must be a power of two
module sep_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cntD;
  logic doPush;
  logic doPop;
  logic notFull_q;
  logic notEmpty_q;

  // Flags come from the next count so both sides see registered levels
  always_comb begin
    doPush = inValid & notFull_q;
    doPop = outReady & notEmpty_q;
    cntD = cnt_q + (AW+1)'(doPush) - (AW+1)'(doPop);
  end

  // Pointers, count and flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
      notFull_q <= 1'b1;
      notEmpty_q <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      cnt_q <= cntD;
      notFull_q <= (cntD != FULL_CNT);
      notEmpty_q <= (cntD != '0);
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  assign inReady = notFull_q;
  assign outValid = notEmpty_q;
  assign outData = mem_q[rdPtr_q];
endmodule : sep_fifo

module sep_host
  import sep_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link
  sep_link_if.host link,
  // Command request
  input wire logic cmdValid,
  output logic cmdReady,
  input wire sep_cmd_t cmdOp,
  input wire logic [SEP_ADDR_W-1:0] cmdAddr,
  input wire logic [SEP_DATA_W-1:0] cmdData,
  input wire logic [SEP_ADDR_W:0] cmdWords,
  // Read data
  output logic rdValid,
  input wire logic rdReady,
  output logic [SEP_DATA_W-1:0] rdData
);
  localparam logic [5:0] HALF_LAST = 6'(SEP_SK_HALF_CYC - 1);
  localparam logic [4:0] DESEL_LAST = 5'(SEP_DESEL_CYC - 1);
  localparam logic [4:0] SETTLE_LAST = 5'(SEP_SETTLE_CYC - 1);
  localparam logic [4:0] LONG_LAST = 5'(SEP_FRAME_W - 1);
  localparam logic [4:0] SHORT_LAST = 5'(SEP_SHORT_LEN - 1);

  sep_host_state_t state_q;
  logic doLvl;
  logic tick;
  logic [5:0] half_q;
  logic cs_q;
  logic sk_q;
  logic di_q;
  logic [SEP_FRAME_W-1:0] tx_q;
  logic [4:0] txLeft_q;
  logic isRead_q;
  logic pollNext_q;
  logic [4:0] wait_q;
  logic [SEP_ADDR_W:0] words_q;
  logic [3:0] rxCnt_q;
  logic [SEP_DATA_W-1:0] rxSh_q;
  logic push_q;
  logic pushReady;
  logic [SEP_DATA_W-1:0] pushData_q;
  logic cmdReady_q;
  logic [1:0] opField;
  logic [SEP_ADDR_W-1:0] adrField;

  sep_sync #(.W(1)) uDo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(link.serialOutLine),
    .level(doLvl)
  );

  // Opcode and address field of the frame being accepted
  always_comb begin
    opField = SEP_OP_SPECIAL;
    adrField = cmdAddr;
    case (cmdOp)
      SC_READ: opField = SEP_OP_READ;
      SC_WRITE: opField = SEP_OP_WRITE;
      SC_ERASE: opField = SEP_OP_ERASE;
      SC_ENABLE: adrField = {SEP_LEAD_ENABLE, (SEP_ADDR_W-2)'(0)};
      default: adrField = {SEP_LEAD_DISABLE, (SEP_ADDR_W-2)'(0)};
    endcase
  end

  // Half-period divider for the serial clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n || half_q == '0) begin
      half_q <= HALF_LAST;
    end else begin
      half_q <= half_q - 6'h1;
    end
  end
  assign tick = (half_q == '0);

  // Link sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= HS_IDLE;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      di_q <= 1'b0;
      tx_q <= '0;
      txLeft_q <= '0;
      isRead_q <= 1'b0;
      pollNext_q <= 1'b0;
      wait_q <= '0;
      words_q <= '0;
      rxCnt_q <= '0;
      rxSh_q <= '0;
      cmdReady_q <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE: begin
          cmdReady_q <= 1'b1;
          if (cmdValid && cmdReady_q) begin
            cmdReady_q <= 1'b0;
            cs_q <= 1'b1;
            tx_q <= {1'b1, opField, adrField, cmdData};
            di_q <= 1'b1;
            txLeft_q <= (cmdOp == SC_WRITE) ? LONG_LAST : SHORT_LAST;
            isRead_q <= (cmdOp == SC_READ);
            pollNext_q <= (cmdOp == SC_WRITE) || (cmdOp == SC_ERASE);
            words_q <= (cmdWords == '0) ? (SEP_ADDR_W+1)'(1) : cmdWords;
            state_q <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (tick && !sk_q) begin
            sk_q <= 1'b1;
          end else if (tick) begin
            sk_q <= 1'b0;
            if (txLeft_q == '0) begin
              di_q <= 1'b0;
              rxCnt_q <= '0;
              if (isRead_q) begin
                state_q <= HS_RECV;
              end else begin
                cs_q <= 1'b0;
                wait_q <= DESEL_LAST;
                state_q <= HS_DESEL;
              end
            end else begin
              tx_q <= tx_q << 1;
              di_q <= tx_q[SEP_FRAME_W-2];
              txLeft_q <= txLeft_q - 5'h1;
            end
          end
        end
        HS_RECV: begin
          // The serial clock waits while a finished word is still unplaced
          if (tick && !sk_q && !push_q) begin
            sk_q <= 1'b1;
          end else if (tick && sk_q) begin
            sk_q <= 1'b0;
            rxSh_q <= {rxSh_q[SEP_DATA_W-2:0], doLvl};
            rxCnt_q <= rxCnt_q + 4'h1;
            if (rxCnt_q == 4'hf) begin
              words_q <= words_q - 1'b1;
              if (words_q == (SEP_ADDR_W+1)'(1)) begin
                cs_q <= 1'b0;
                pollNext_q <= 1'b0;
                wait_q <= DESEL_LAST;
                state_q <= HS_DESEL;
              end
            end
          end
        end
        HS_DESEL: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 5'h1;
          end else if (pollNext_q) begin
            cs_q <= 1'b1;
            wait_q <= SETTLE_LAST;
            state_q <= HS_POLL;
          end else begin
            state_q <= HS_IDLE;
          end
        end
        HS_POLL: begin
          // Serial input stays low for the whole wait
          di_q <= 1'b0;
          if (wait_q != '0) begin
            wait_q <= wait_q - 5'h1;
          end else if (doLvl) begin
            cs_q <= 1'b0;
            pollNext_q <= 1'b0;
            wait_q <= DESEL_LAST;
            state_q <= HS_DESEL;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Completed words wait here until the buffer takes them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      pushData_q <= '0;
    end else if (state_q == HS_RECV && tick && sk_q && rxCnt_q == 4'hf) begin
      push_q <= 1'b1;
      pushData_q <= {rxSh_q[SEP_DATA_W-2:0], doLvl};
    end else if (pushReady) begin
      push_q <= 1'b0;
    end
  end

  sep_fifo #(.W(SEP_DATA_W), .D(SEP_FIFO_DEPTH)) uBuf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(push_q),
    .inReady(pushReady),
    .inData(pushData_q),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  assign cmdReady = cmdReady_q;
  assign link.chipSelect = cs_q;
  assign link.serialClock = sk_q;
  assign link.serialIn = di_q;
endmodule : sep_host

// *** tb/sep_link_props.sv ***
// Link checker for the serial EEPROM command port, watching the four pins and status.
// Assumes the bench wires it beside the one link interface that joins both ends.
`timescale 1ns/1ns
module sep_link_props #(
  parameter int PROG_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe,
  // Device status
  input wire logic progBusy,
  input wire logic writeEnabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  int busyCnt;

  // Length of the running program, so the cycle figure can be checked at its end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !progBusy) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= busyCnt + 1;
    end
  end

  // Long enough for the pin samplers to see chip select low
  sequence s_deselected;
    !chipSelect [*8];
  endsequence
  sequence s_busy2;
    progBusy [*2];
  endsequence

  a_standby_float: assert property (s_deselected |-> !serialOutOe)
    else $error("serial output driven while deselected");
  a_busy_low: assert property (s_busy2 |-> !$past(serialOutOe) || !$past(serialOut))
    else $error("serial output high during programming");
  a_prog_gate: assert property ($rose(progBusy) |-> writeEnabled)
    else $error("programming began while write disabled");
  a_prog_start: assert property ($rose(progBusy) |-> !chipSelect && !$past(chipSelect, 3))
    else $error("programming began with chip select high");
  a_prog_time: assert property ($fell(progBusy) |->
      busyCnt >= PROG_CYCLES - 2 && busyCnt <= PROG_CYCLES + 2)
    else $error("programming length wrong");
  a_ready_high: assert property ($fell(progBusy) && chipSelect && $past(chipSelect, 8) |->
      ##[0:4] (serialOutOe && serialOut))
    else $error("ready level not shown after programming");
  a_shift_clock: assert property ($changed(serialOut) && serialOutOe && $past(serialOutOe)
      && !progBusy && !$past(progBusy, 2) |-> serialClock && chipSelect)
    else $error("read bit moved without a serial clock rise");
  a_wen_change: assert property ($changed(writeEnabled) |-> !chipSelect && !$past(chipSelect, 3))
    else $error("write enable changed inside a frame");

  c_start_seen: cover property (chipSelect && serialIn && $rose(serialClock));
endmodule : sep_link_props

// *** tb/serial_eeprom_command_port_test.sv ***
// Bench for both link ends: drives the host command port, models the array.
// Assumes sep_pkg, the link interface, device, host and checker are compiled first.
`timescale 1ns/1ns
module serial_eeprom_command_port_test;
  import sep_pkg::*;
  localparam int PROG = 200;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic rdReady = 1'b0;
  logic cmdReady, rdValid, progBusy, writeEnabled;
  sep_cmd_t cmdOp = SC_READ;
  logic [SEP_ADDR_W-1:0] cmdAddr = '0;
  logic [SEP_DATA_W-1:0] cmdData = '0;
  logic [SEP_ADDR_W:0] cmdWords = '0;
  logic [SEP_DATA_W-1:0] rdData;
  logic [15:0] mem [1024];
  logic wen = 1'b0;
  int n_mismatch = 0;
  int checks = 0;

  // Free-running 125 MHz reference
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  sep_link_if link();
  sep_device #(.PROG_CYCLES(PROG)) sep_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .progBusy(progBusy), .writeEnabled(writeEnabled));
  sep_host sep_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdWords(cmdWords), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  sep_link_props #(.PROG_CYCLES(PROG)) sep_link_props_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .chipSelect(link.chipSelect), .serialClock(link.serialClock), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .serialOutOe(link.serialOutOe), .progBusy(progBusy),
    .writeEnabled(writeEnabled));

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded wait for the host to finish its whole sequence
  task automatic waitReady();
    int i;
    i = 0;
    while (cmdReady !== 1'b1 && i < 40000) begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 40000) begin
      check("timeout", 16'h1, 16'h0);
      summarize();
    end
  endtask : waitReady

  // One command; the model follows the enable latch and array contents
  task automatic send(sep_cmd_t op, int addr, logic [15:0] data, int words);
    waitReady();
    cmdOp = op;
    cmdAddr = addr[9:0];
    cmdData = data;
    cmdWords = words[10:0];
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    if (op == SC_ENABLE) wen = 1'b1;
    if (op == SC_DISABLE) wen = 1'b0;
    if (op == SC_WRITE && wen) mem[addr] = data;
    if (op == SC_ERASE && wen) mem[addr] = 16'hffff;
  endtask : send

  // Sequential read; the drain side stalls until hold cycles pass, so finished words queue in the FIFO
  task automatic readSeq(int addr, int n, int hold);
    int got, i;
    got = 0;
    i = 0;
    send(SC_READ, addr, 16'h0, n);
    while (got < n && i < 60000) begin
      rdReady = (i > hold) && ($urandom_range(0, 2) != 0);
      if (rdReady && rdValid === 1'b1) begin
        check("rdData", rdData, mem[(addr + got) % 1024]);
        got++;
      end
      @(negedge ref_clk);
      i++;
    end
    rdReady = 1'b0;
    if (i >= 60000) begin
      check("timeout", 16'h1, 16'h0);
      summarize();
    end
    waitReady();
    check("words", 16'(got), 16'(n));
    check("rdValid", {15'h0, rdValid}, 16'h0);
  endtask : readSeq

  // Main sequence
  initial begin
    for (int a = 0; a < 1024; a++) mem[a] = 16'hffff;
    void'($urandom(32'h4235e020));
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check("writeEnabled", {15'h0, writeEnabled}, 16'h0);
    send(SC_WRITE, 5, 16'h1234, 0);
    readSeq(5, 1, 0);
    send(SC_ENABLE, 0, 16'h0, 0);
    waitReady();
    check("writeEnabled", {15'h0, writeEnabled}, 16'h1);
    // Writes over stored data need no erase first
    send(SC_WRITE, 'h3fe, 16'($urandom), 0);
    send(SC_WRITE, 'h3ff, 16'($urandom), 0);
    send(SC_WRITE, 0, 16'($urandom), 0);
    send(SC_WRITE, 'h3fe, 16'($urandom), 0);
    send(SC_ERASE, 'h3ff, 16'h0, 0);
    // Ten words across the top of the array, drained late
    readSeq('h3fc, 10, 12000);
    send(SC_DISABLE, 0, 16'h0, 0);
    waitReady();
    check("writeEnabled", {15'h0, writeEnabled}, 16'h0);
    send(SC_ERASE, 0, 16'h0, 0);
    readSeq(0, 1, 0);
    summarize();
  end
endmodule : serial_eeprom_command_port_test
